// File: bus_seq_pkg.sv
package bus_seq_pkg;

    // ----------------------------------------------------------------
    // Bus timing
    // ----------------------------------------------------------------
    // Clocks per bus cycle; leaves room for the two-flop data sync
    localparam int unsigned BUS_DIV = 4;
    localparam logic [1:0]  DIV_LAST = 2'h3;
    localparam logic [3:0]  CNT_W_ZERO = 4'h0;

    // ----------------------------------------------------------------
    // Address arithmetic and reset values
    // ----------------------------------------------------------------
    localparam logic [15:0] ONE16 = 16'h0001;
    localparam logic [15:0] TWO16 = 16'h0002;
    localparam logic [15:0] THREE16 = 16'h0003;
    localparam logic [7:0]  PAGE_ZERO = 8'h00;
    localparam logic [15:0] ADDR_RST = 16'h0000;
    localparam logic [7:0]  BYTE_RST = 8'h00;

    // ----------------------------------------------------------------
    // Instruction classes and sequencer steps
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        K_READ8,            // load_accum_a / load_accum_b and other one-byte reads
        K_READ16,           // load_index_reg, load_stack_ptr, compare_index_reg
        K_STORE_ACC,        // store_accum
        K_STORE_REG,        // store_stack_ptr, store_index_reg
        K_JMP,              // jump_absolute
        K_JSR               // jump_to_subroutine
    } op_kind_t;

    typedef enum logic [3:0] {
        ST_IDLE, ST_OPC, ST_ADRH, ST_ADRL, ST_DUMMY, ST_DATA_A, ST_DATA_B,
        ST_JSR_START, ST_PUSH_L, ST_PUSH_H, ST_JSR_IDLE1, ST_JSR_IDLE2, ST_JSR_LAST
    } step_t;

    // Request handed over by the processor_core control
    typedef struct packed {
        op_kind_t    kind;   // instruction class
        logic        ext;    // 1 = extended, 0 = direct
        logic [15:0] pc;     // opcode address
        logic [7:0]  acc;    // accumulator to store
        logic [15:0] regv;   // index or stack register to store
        logic [15:0] sp;     // stack pointer for subroutine call
    } instr_req_t;

endpackage

// File: direct_extended_bus_sequencer.sv
`timescale 1ns/1ns

// Notes on behaviour
// RULE1 - Direct mode fetches one address byte; operand lies in page zero. The code puts the second byte of a two-byte operand at 00FF at 0100.
// RULE2 - Extended mode fetches a two-byte address, high byte first.
// RULE3 - Direct one-byte read: opcode, address byte, operand read; three valid reads.
// RULE4 - Direct 16-bit load or compare: four cycles, high byte then low byte.
// RULE5 - Direct accumulator store: dummy cycle with access low, then write.
// RULE6 - Direct register store: five cycles, dummy, then high and low byte writes.
// RULE7 - Extended register store: six cycles, dummy, then two byte writes.
// RULE8 - Extended subroutine call: nine cycles, two pushes, two idle cycles.
// RULE9 - Extended jump: three reads, then continue at fetched target.
// RULE10 - Memory tri-states data while valid access is low.
// RULE11 - Extended accumulator store: five cycles with dummy before the write.
// RULE12 - Read/write high on reads; valid access high only on real references.
module direct_extended_bus_sequencer (
    input  wire logic                   clk,        // 100 MHz clock
    input  wire logic                   sys_rst,    // Synchronous reset, high
    input  wire logic                   start,      // Begin an instruction
    input  wire bus_seq_pkg::instr_req_t req,        // Instruction to sequence
    input  wire logic [7:0]             data_in,    // Data bus pin input
    output logic [7:0]                  data_out,   // Data bus pin output
    output logic                        data_oe,    // Data bus drive enable
    output logic [15:0]                 addr,       // Address bus
    output logic                        rw,         // High read, low write
    output logic                        valid_memory_access, // Real bus reference
    output logic                        busy,       // Instruction in progress
    output logic                        done,       // One-cycle end pulse
    output logic [15:0]                 rd_data,    // Operand read back
    output logic [15:0]                 next_pc     // Where execution continues
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    bus_seq_pkg::step_t      state_q, state_d;
    bus_seq_pkg::instr_req_t req_q;
    logic [1:0]              div_q;
    logic [3:0]              cyc_q;
    logic [15:0]             ea_q;
    logic [7:0]              din_s1_q, din_s2_q;

    // ----------------------------------------------------------------
    // Pin synchroniser
    // ----------------------------------------------------------------
    // Data pin comes from outside; only the second stage is read
    always_ff @(posedge clk) begin
        din_s1_q <= data_in;
        din_s2_q <= din_s1_q;
    end

    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    // Bus cycle boundary, and the fields of the latched request
    wire tick = busy && (div_q == bus_seq_pkg::DIV_LAST);
    wire accept = !busy && start;
    wire is_ext = req_q.ext || (req_q.kind == bus_seq_pkg::K_JMP) || (req_q.kind == bus_seq_pkg::K_JSR);
    wire two_bytes = (req_q.kind == bus_seq_pkg::K_READ16) || (req_q.kind == bus_seq_pkg::K_STORE_REG);
    wire is_store = (req_q.kind == bus_seq_pkg::K_STORE_ACC) || (req_q.kind == bus_seq_pkg::K_STORE_REG);
    wire is_read = (req_q.kind == bus_seq_pkg::K_READ8) || (req_q.kind == bus_seq_pkg::K_READ16);
    wire [15:0] ret_addr = req_q.pc + bus_seq_pkg::THREE16;

    // Effective address as it stands once this cycle's byte is taken
    wire [15:0] ea_d = (state_q == bus_seq_pkg::ST_ADRH) ? {din_s2_q, ea_q[7:0]}
                     : (state_q == bus_seq_pkg::ST_ADRL) ? {ea_q[15:8], din_s2_q} : ea_q;

    // Step order; direct mode skips the high address byte
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            bus_seq_pkg::ST_IDLE:      state_d = bus_seq_pkg::ST_IDLE;
            bus_seq_pkg::ST_OPC:       state_d = is_ext ? bus_seq_pkg::ST_ADRH : bus_seq_pkg::ST_ADRL; // [RULE1] [RULE2]
            bus_seq_pkg::ST_ADRH:      state_d = bus_seq_pkg::ST_ADRL;
            bus_seq_pkg::ST_ADRL: begin
                if (is_read)
                    state_d = bus_seq_pkg::ST_DATA_A;                          // [RULE3] [RULE4]
                else if (is_store)
                    state_d = bus_seq_pkg::ST_DUMMY;                           // [RULE5] [RULE6] [RULE7] [RULE11]
                else if (req_q.kind == bus_seq_pkg::K_JSR)
                    state_d = bus_seq_pkg::ST_JSR_START;                       // [RULE8]
                else
                    state_d = bus_seq_pkg::ST_IDLE;                            // [RULE9]
            end
            bus_seq_pkg::ST_DUMMY:     state_d = bus_seq_pkg::ST_DATA_A;
            bus_seq_pkg::ST_DATA_A:    state_d = two_bytes ? bus_seq_pkg::ST_DATA_B : bus_seq_pkg::ST_IDLE;
            bus_seq_pkg::ST_DATA_B:    state_d = bus_seq_pkg::ST_IDLE;
            bus_seq_pkg::ST_JSR_START: state_d = bus_seq_pkg::ST_PUSH_L;
            bus_seq_pkg::ST_PUSH_L:    state_d = bus_seq_pkg::ST_PUSH_H;
            bus_seq_pkg::ST_PUSH_H:    state_d = bus_seq_pkg::ST_JSR_IDLE1;
            bus_seq_pkg::ST_JSR_IDLE1: state_d = bus_seq_pkg::ST_JSR_IDLE2;
            bus_seq_pkg::ST_JSR_IDLE2: state_d = bus_seq_pkg::ST_JSR_LAST;
            bus_seq_pkg::ST_JSR_LAST:  state_d = bus_seq_pkg::ST_IDLE;
            default:                   state_d = bus_seq_pkg::ST_IDLE;
        endcase
    end

    // Bus drive for the step about to start
    logic [15:0] addr_d;
    logic [7:0]  dout_d;
    logic        rw_d, vma_d;
    bus_seq_pkg::step_t step_n;
    assign step_n = accept ? bus_seq_pkg::ST_OPC : state_d;
    always_comb begin
        addr_d = addr;
        dout_d = bus_seq_pkg::BYTE_RST;
        rw_d = 1'b1;
        vma_d = 1'b1;
        unique case (step_n)
            bus_seq_pkg::ST_IDLE:      vma_d = 1'b0;
            bus_seq_pkg::ST_OPC:       addr_d = accept ? req.pc : req_q.pc;
            bus_seq_pkg::ST_ADRH:      addr_d = req_q.pc + bus_seq_pkg::ONE16;                    // [RULE2]
            bus_seq_pkg::ST_ADRL:      addr_d = req_q.pc + (is_ext ? bus_seq_pkg::TWO16 : bus_seq_pkg::ONE16);
            bus_seq_pkg::ST_DUMMY: begin
                addr_d = ea_d;
                vma_d = 1'b0;                                                       // [RULE12]
            end
            bus_seq_pkg::ST_DATA_A: begin
                addr_d = ea_d;
                rw_d = !is_store;                                                   // [RULE12]
                dout_d = (req_q.kind == bus_seq_pkg::K_STORE_ACC) ? req_q.acc : req_q.regv[15:8];
            end
            bus_seq_pkg::ST_DATA_B: begin
                addr_d = ea_q + bus_seq_pkg::ONE16;                                 // [RULE4] [RULE6] [RULE7]
                rw_d = !is_store;
                dout_d = req_q.regv[7:0];
            end
            bus_seq_pkg::ST_JSR_START: addr_d = ea_d;                               // [RULE8]
            bus_seq_pkg::ST_PUSH_L: begin
                addr_d = req_q.sp;
                rw_d = 1'b0;
                dout_d = ret_addr[7:0];
            end
            bus_seq_pkg::ST_PUSH_H: begin
                addr_d = req_q.sp - bus_seq_pkg::ONE16;
                rw_d = 1'b0;
                dout_d = ret_addr[15:8];
            end
            bus_seq_pkg::ST_JSR_IDLE1: begin
                addr_d = req_q.sp - bus_seq_pkg::TWO16;
                vma_d = 1'b0;                                                       // [RULE8]
            end
            bus_seq_pkg::ST_JSR_IDLE2: begin
                addr_d = req_q.pc + bus_seq_pkg::TWO16;
                vma_d = 1'b0;
            end
            bus_seq_pkg::ST_JSR_LAST:  addr_d = req_q.pc + bus_seq_pkg::TWO16;
            default:                   vma_d = 1'b0;
        endcase
    end

    // ----------------------------------------------------------------
    // Sequencer registers
    // ----------------------------------------------------------------
    // Request latched once so the caller may change it mid-instruction
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_q <= bus_seq_pkg::ST_IDLE;
            busy <= 1'b0;
            div_q <= 2'h0;
            cyc_q <= bus_seq_pkg::CNT_W_ZERO;
        end else if (accept) begin
            state_q <= bus_seq_pkg::ST_OPC;
            busy <= 1'b1;
            div_q <= 2'h0;
            cyc_q <= bus_seq_pkg::CNT_W_ZERO;
        end else if (busy) begin
            div_q <= div_q + 2'h1;
            if (tick) begin
                state_q <= state_d;
                busy <= (state_d != bus_seq_pkg::ST_IDLE);
                cyc_q <= cyc_q + 4'h1;
            end
        end
    end

    // Request copy and effective address; direct mode starts in page zero
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            req_q <= '0;
            ea_q <= bus_seq_pkg::ADDR_RST;
        end else if (accept) begin
            req_q <= req;
            ea_q <= {bus_seq_pkg::PAGE_ZERO, bus_seq_pkg::BYTE_RST};  // [RULE1]
        end else if (tick) begin
            ea_q <= ea_d;
        end
    end

    // Pin drive; the data bus is driven only on write cycles
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            addr <= bus_seq_pkg::ADDR_RST;
            data_out <= bus_seq_pkg::BYTE_RST;
            data_oe <= 1'b0;
            rw <= 1'b1;
            valid_memory_access <= 1'b0;
        end else if (accept || tick) begin
            addr <= addr_d;
            data_out <= dout_d;
            data_oe <= !rw_d;
            rw <= rw_d;                                                             // [RULE12]
            valid_memory_access <= vma_d;                                           // [RULE12]
        end
    end

    // Read data capture and completion report
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rd_data <= bus_seq_pkg::ADDR_RST;
            next_pc <= bus_seq_pkg::ADDR_RST;
            done <= 1'b0;
        end else begin
            done <= tick && (state_d == bus_seq_pkg::ST_IDLE);
            if (tick && state_q == bus_seq_pkg::ST_DATA_A && is_read)
                rd_data <= two_bytes ? {din_s2_q, rd_data[7:0]} : {bus_seq_pkg::PAGE_ZERO, din_s2_q};
            if (tick && state_q == bus_seq_pkg::ST_DATA_B && is_read)
                rd_data <= {rd_data[15:8], din_s2_q};                               // [RULE4]
            if (tick && state_d == bus_seq_pkg::ST_IDLE)
                next_pc <= (req_q.kind == bus_seq_pkg::K_JMP || req_q.kind == bus_seq_pkg::K_JSR)
                         ? ea_d : req_q.pc + (is_ext ? bus_seq_pkg::THREE16 : bus_seq_pkg::TWO16); // [RULE9]
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence s_dummy_cycle;
        state_q == bus_seq_pkg::ST_DUMMY && tick;
    endsequence

    chk_direct_page_zero: assert property ( // [RULE1]
        state_q == bus_seq_pkg::ST_DATA_A && !is_ext |-> addr[15:8] == bus_seq_pkg::PAGE_ZERO)
        else $error("direct operand outside page zero");
    chk_ext_low_addr: assert property ( // [RULE2]
        state_q == bus_seq_pkg::ST_ADRL && is_ext |-> addr == req_q.pc + bus_seq_pkg::TWO16)
        else $error("extended low address byte fetched from wrong place");
    chk_read8_len: assert property ( // [RULE3]
        done && req_q.kind == bus_seq_pkg::K_READ8 && !req_q.ext |-> cyc_q == 4'h3)
        else $error("direct byte read not three cycles");
    chk_read16_len: assert property ( // [RULE4]
        done && req_q.kind == bus_seq_pkg::K_READ16 && !req_q.ext |-> cyc_q == 4'h4)
        else $error("direct word read not four cycles");
    chk_dummy_then_write: assert property ( // [RULE5]
        s_dummy_cycle |=> !rw && valid_memory_access && data_oe && $stable(addr))
        else $error("store dummy not followed by write at same address");
    chk_reg_store_len: assert property ( // [RULE6]
        done && req_q.kind == bus_seq_pkg::K_STORE_REG |-> cyc_q == (req_q.ext ? 4'h6 : 4'h5))
        else $error("register store length wrong");
    chk_ext_store_low: assert property ( // [RULE7]
        state_q == bus_seq_pkg::ST_DATA_B && req_q.kind == bus_seq_pkg::K_STORE_REG
        |-> !rw && addr == ea_q + bus_seq_pkg::ONE16 && data_out == req_q.regv[7:0])
        else $error("register low byte store wrong");
    chk_jsr_push: assert property ( // [RULE8]
        state_q == bus_seq_pkg::ST_PUSH_H |-> addr == req_q.sp - bus_seq_pkg::ONE16 && !rw
        && data_out == ret_addr[15:8])
        else $error("return high byte push wrong");
    chk_jsr_len: assert property ( // [RULE8]
        done && req_q.kind == bus_seq_pkg::K_JSR |-> cyc_q == 4'h9)
        else $error("subroutine call not nine cycles");
    chk_jmp_target: assert property ( // [RULE9]
        done && req_q.kind == bus_seq_pkg::K_JMP |-> cyc_q == 4'h3 && next_pc == ea_q)
        else $error("jump length or target wrong");
    chk_acc_store_len: assert property ( // [RULE11]
        done && req_q.kind == bus_seq_pkg::K_STORE_ACC |-> cyc_q == (req_q.ext ? 4'h5 : 4'h4))
        else $error("accumulator store length wrong");
    chk_write_valid: assert property ( // [RULE12]
        !rw |-> valid_memory_access && data_oe)
        else $error("write cycle without valid access");

endmodule

// File: bus_mem_model.sv
`timescale 1ns/1ns

// ----------------------------------------------------------------
// Memory and peripherals on the far side of the bus
// ----------------------------------------------------------------
module bus_mem_model (
    input  wire logic        clk,                 // System clock
    input  wire logic [15:0] addr,                // Address bus
    input  wire logic        rw,                  // High read, low write
    input  wire logic        valid_memory_access, // Real bus reference
    input  wire logic        data_oe,             // Processor drives data
    input  wire logic [7:0]  data_out,            // Processor write data
    input  wire logic        slow,                // Late answer on reads
    output logic      [7:0]  data_in              // Data bus seen by processor
);
    logic [7:0]  mem [0:65535];
    logic [7:0]  last_q;
    logic [15:0] addr_q;
    wire         drive;

    // Slow parts answer one clock after the address settles
    assign drive = valid_memory_access && rw && !(slow && addr != addr_q);
    // No pull on the bus, so an undriven cycle shows the inverse byte
    assign data_in = drive ? mem[addr] : ~last_q;

    // Track address, last byte driven and accepted writes
    always @(posedge clk) begin
        addr_q <= addr;
        if (drive) begin
            last_q <= mem[addr];
        end
        if (valid_memory_access && !rw && data_oe) begin
            mem[addr] <= data_out;
        end
    end

    // Blank memory so unset places read as zero
    initial begin
        last_q = 8'h00;
        addr_q = 16'h0000;
        foreach (mem[i]) begin
            mem[i] = 8'h00;
        end
    end
endmodule

// File: direct_extended_bus_sequencer_bench.sv
`timescale 1ns/1ns

module direct_extended_bus_sequencer_bench;
    // ----------------------------------------------------------------
    // Stimulus, design and memory
    // ----------------------------------------------------------------
    logic                    clk = 1'b0;
    logic                    sys_rst = 1'b1;
    logic                    start = 1'b0;
    logic                    slow = 1'b0;
    bus_seq_pkg::instr_req_t req = '0;
    logic [7:0]              data_in;
    logic [7:0]              data_out;
    logic                    data_oe;
    logic [15:0]             addr;
    logic                    rw;
    logic                    valid_memory_access;
    logic                    busy;
    logic                    done;
    logic [15:0]             rd_data;
    logic [15:0]             next_pc;
    int                      error_cnt = 0;
    int                      n_tests = 0;
    int                      cycles = 0;
    logic [26:0]             q[$];

    always #5 clk = ~clk;

    direct_extended_bus_sequencer uut (.clk(clk), .sys_rst(sys_rst), .start(start), .req(req),
        .data_in(data_in), .data_out(data_out), .data_oe(data_oe), .addr(addr), .rw(rw),
        .valid_memory_access(valid_memory_access), .busy(busy), .done(done), .rd_data(rd_data),
        .next_pc(next_pc));

    bus_mem_model mem_i (.clk(clk), .addr(addr), .rw(rw), .valid_memory_access(valid_memory_access),
        .data_oe(data_oe), .data_out(data_out), .slow(slow), .data_in(data_in));

    // ----------------------------------------------------------------
    // Shared helpers
    // ----------------------------------------------------------------
    task automatic summarize();
        if (error_cnt == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Hang guard: a few hundred clocks are enough for all scenarios
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            error_cnt++;
            summarize();
        end
    end

    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Expected bus cycle: address, access, direction, drive, write byte
    task automatic add(input logic [15:0] a, input logic v, input logic r, input logic [7:0] d);
        q.push_back({a, v, r, ~r, r ? 8'h00 : d});
    endtask

    task automatic rd(input logic [15:0] a);
        add(a, 1'b1, 1'b1, 8'h00);
    endtask

    task automatic put2(input logic [15:0] a, input logic [15:0] d);
        mem_i.mem[a] = d[15:8];
        mem_i.mem[a + 16'h0001] = d[7:0];
    endtask

    // Start at this falling edge, check every bus cycle half a clock after it begins, then the end pulse
    task automatic go(input bus_seq_pkg::op_kind_t k, input logic x, input logic [15:0] pc,
                      input logic hold, input logic [15:0] exp_rd, input logic [15:0] exp_pc);
        int n;
        q.push_front({pc, 1'b1, 1'b1, 1'b0, 8'h00});
        n = q.size();
        req.kind = k;
        req.ext = x;
        req.pc = pc;
        start = 1'b1;
        @(negedge clk);
        start = hold;
        for (int i = 0; i < n; i++) begin
            chk({12'h000, busy, addr, valid_memory_access, rw, data_oe, data_oe ? data_out : 8'h00},
                {12'h000, 1'b1, q[i]});
            repeat (4) @(negedge clk);
        end
        // Read result must hold across instructions that do not read an operand
        chk({6'h00, done, busy, next_pc, rd_data},
            {6'h00, 2'b10, exp_pc, exp_rd});
        q.delete();
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic s_read8();
        mem_i.mem[16'h1235] = 8'hFF;
        mem_i.mem[16'h00FF] = 8'h5A;
        rd(16'h1235);
        rd(16'h00FF);
        go(bus_seq_pkg::K_READ8, 1'b0, 16'h1234, 1'b0, 16'h005A, 16'h1236);
        put2(16'h2001, 16'hFFFF);
        mem_i.mem[16'hFFFF] = 8'hC3;
        rd(16'h2001);
        rd(16'h2002);
        rd(16'hFFFF);
        go(bus_seq_pkg::K_READ8, 1'b1, 16'h2000, 1'b0, 16'h00C3, 16'h2003);
    endtask

    // Slow memory: answer arrives a clock late
    task automatic s_read16();
        slow = 1'b1;
        mem_i.mem[16'h3001] = 8'h80;
        put2(16'h0080, 16'h1234);
        rd(16'h3001);
        rd(16'h0080);
        rd(16'h0081);
        go(bus_seq_pkg::K_READ16, 1'b0, 16'h3000, 1'b0, 16'h1234, 16'h3002);
        slow = 1'b0;
    endtask

    // Extended store keeps start high throughout, which must be ignored
    task automatic s_store_acc();
        req.acc = 8'hA5;
        mem_i.mem[16'h4001] = 8'h10;
        rd(16'h4001);
        add(16'h0010, 1'b0, 1'b1, 8'h00);
        add(16'h0010, 1'b1, 1'b0, 8'hA5);
        go(bus_seq_pkg::K_STORE_ACC, 1'b0, 16'h4000, 1'b0, 16'h1234, 16'h4002);
        req.acc = 8'h3C;
        put2(16'h4101, 16'h1234);
        rd(16'h4101);
        rd(16'h4102);
        add(16'h1234, 1'b0, 1'b1, 8'h00);
        add(16'h1234, 1'b1, 1'b0, 8'h3C);
        go(bus_seq_pkg::K_STORE_ACC, 1'b1, 16'h4100, 1'b1, 16'h1234, 16'h4103);
        chk({24'h0, mem_i.mem[16'h0010], mem_i.mem[16'h1234]}, 40'hA53C);
    endtask

    // Direct store crosses from the end of page zero into the next page
    task automatic s_store_reg();
        req.regv = 16'hBEEF;
        mem_i.mem[16'h5001] = 8'hFF;
        rd(16'h5001);
        add(16'h00FF, 1'b0, 1'b1, 8'h00);
        add(16'h00FF, 1'b1, 1'b0, 8'hBE);
        add(16'h0100, 1'b1, 1'b0, 8'hEF);
        go(bus_seq_pkg::K_STORE_REG, 1'b0, 16'h5000, 1'b0, 16'h1234, 16'h5002);
        req.regv = 16'h1357;
        put2(16'h5101, 16'hABCD);
        rd(16'h5101);
        rd(16'h5102);
        add(16'hABCD, 1'b0, 1'b1, 8'h00);
        add(16'hABCD, 1'b1, 1'b0, 8'h13);
        add(16'hABCE, 1'b1, 1'b0, 8'h57);
        go(bus_seq_pkg::K_STORE_REG, 1'b1, 16'h5100, 1'b0, 16'h1234, 16'h5103);
    endtask

    task automatic s_jumps();
        put2(16'h6001, 16'h789A);
        rd(16'h6001);
        rd(16'h6002);
        go(bus_seq_pkg::K_JMP, 1'b1, 16'h6000, 1'b0, 16'h1234, 16'h789A);
        req.sp = 16'h01FF;
        put2(16'h7001, 16'h8123);
        rd(16'h7001);
        rd(16'h7002);
        rd(16'h8123);
        add(16'h01FF, 1'b1, 1'b0, 8'h03);
        add(16'h01FE, 1'b1, 1'b0, 8'h70);
        add(16'h01FD, 1'b0, 1'b1, 8'h00);
        add(16'h7002, 1'b0, 1'b1, 8'h00);
        rd(16'h7002);
        go(bus_seq_pkg::K_JSR, 1'b1, 16'h7000, 1'b0, 16'h1234, 16'h8123);
        chk({24'h0, mem_i.mem[16'h01FE], mem_i.mem[16'h01FF]}, 40'h7003);
    endtask

    // Reset in the middle of a read: bus idles at once, results clear, next start still works
    task automatic s_reset_mid();
        req.kind = bus_seq_pkg::K_READ8;
        req.ext = 1'b0;
        req.pc = 16'h9000;
        start = 1'b1;
        @(negedge clk);
        start = 1'b0;
        repeat (6) @(negedge clk);
        sys_rst = 1'b1;
        repeat (2) @(negedge clk);
        chk({19'h0, addr, valid_memory_access, rw, data_oe, busy, done}, 40'h08);
        chk({8'h00, rd_data, next_pc}, 40'h0);
        sys_rst = 1'b0;
        rd(16'h6001);
        rd(16'h6002);
        go(bus_seq_pkg::K_JMP, 1'b1, 16'h6000, 1'b0, 16'h0000, 16'h789A);
    endtask

    // ----------------------------------------------------------------
    // Main sequence: instructions run back to back
    // ----------------------------------------------------------------
    initial begin
        repeat (12) @(negedge clk);
        chk({19'h0, addr, valid_memory_access, rw, data_oe, busy, done}, 40'h08);
        sys_rst = 1'b0;
        s_read8();
        s_read16();
        s_store_acc();
        s_store_reg();
        s_jumps();
        s_reset_mid();
        start = 1'b0;
        repeat (4) @(negedge clk);
        summarize();
    end
endmodule
